// ===== rtl/cvr_consts.vh
// Constants for the comparator voltage reference control block
`ifndef CVR_CONSTS_VH
`define CVR_CONSTS_VH
`define CVR_ADDR_W          2
`define CVR_ADDR_CTRL       2'h0
`define CVR_ADDR_STATUS     2'h1
`define CVR_ADDR_TAP        2'h2
`define CVR_CTRL_RESET      8'h00
`define CVR_BIT_CMP1_SEL    7
`define CVR_BIT_CMP2_SEL    6
`define CVR_BIT_RANGE       5
`define CVR_BIT_FIXED_EN    4
`define CVR_LEVEL_HI        3
`define CVR_LEVEL_LO        0
`define CVR_LOW_DIV         8'h18
`define CVR_HIGH_DIV        8'h20
`define CVR_HIGH_BASE       8'h08
`define CVR_RDATA_IDLE      32'h0000_0000
`endif

// ===== rtl/cvr_ladder_tap.v
// Ladder tap selection: numerator and denominator of the ladder fraction of supply
`timescale 1ns/100ps
`include "cvr_consts.vh"
module cvr_ladder_tap (
  input  wire       i_low_range,   // One selects low range
  input  wire [3:0] i_level,       // Level code 0..15
  output wire [7:0] o_tap_num,     // Fraction numerator
  output wire [7:0] o_tap_den      // Fraction denominator
);
  // Low: level/24. High: 1/4 + level/32 = (8 + level)/32
  assign o_tap_num = i_low_range ? {4'h0, i_level}
                                 : (`CVR_HIGH_BASE + {4'h0, i_level});   // see (R3)
  assign o_tap_den = i_low_range ? `CVR_LOW_DIV : `CVR_HIGH_DIV;         // see (R3)
endmodule // cvr_ladder_tap

// ===== rtl/cvr_ref_ctrl.v
// Comparator voltage reference control: Avalon-MM register and analog control outputs
`timescale 1ns/100ps
`include "cvr_consts.vh"
// Contract
// (R1) Bit 5 selects ladder range: one low, zero high.
// (R2) Bits 3..0 hold a 4-bit level code, 16 levels per range.
// (R3) Low range level/24 of supply; high range 1/4 plus level/32.
// (R4) Bit 7 set powers ladder and routes it to comparator 1, else fixed.
// (R5) Bit 6 set powers ladder and routes it to comparator 2, else fixed.
// (R6) Ladder current off when both select bits clear, on otherwise.
// (R7) Bit 4 enables the 0.6 V fixed reference.
// (R8) Fixed reference stays on while high-frequency oscillator runs.
// (R9) Fixed reference disabled drives ground and draws no current.
// (R10) Reference controls independent of comparator mode settings.
// (R11) Software waits a settling delay after enabling fixed reference.
// (R12) Outputs show register contents from the cycle after a write.
module cvr_ref_ctrl (
  input  wire        i_core_clk,              // Core clock, 100 MHz
  input  wire        i_reset_n,               // Sync reset, active low
  input  wire [1:0]  i_avs_address,           // Word address
  input  wire        i_avs_read,              // Read request
  input  wire        i_avs_write,             // Write request
  input  wire [31:0] i_avs_writedata,         // Write data
  input  wire [3:0]  i_avs_byteenable,        // Byte enables
  output reg  [31:0] o_avs_readdata,          // Read data
  output reg         o_avs_waitrequest,       // Stall, low on answer cycle
  input  wire        i_high_freq_internal_osc, // Oscillator active, async
  output reg         o_ladder_power_en,       // Ladder divider current on
  output reg         o_ladder_range_select,   // One low range
  output reg  [3:0]  o_ladder_level_code,     // Ladder level code
  output reg         o_cmp1_ladder_select,    // Comparator 1 takes ladder
  output reg         o_cmp2_ladder_select,    // Comparator 2 takes ladder
  output reg         o_fixed_ref_enable,      // Fixed reference powered
  output reg         o_fixed_ref_clamp        // Fixed output held at ground
);
  reg  [7:0]  voltage_reference_control_reg;
  reg  [7:0]  ctrl_next;
  reg         answered_reg;
  wire        osc_sync;
  wire [7:0]  tap_num;
  wire [7:0]  tap_den;
  wire        req;
  reg  [31:0] rdata_next;

  cvr_sync2 u_osc_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    (i_high_freq_internal_osc),
    .o_sync     (osc_sync)
  );

  cvr_ladder_tap u_tap (
    .i_low_range (voltage_reference_control_reg[`CVR_BIT_RANGE]),
    .i_level     (voltage_reference_control_reg[`CVR_LEVEL_HI:`CVR_LEVEL_LO]),
    .o_tap_num   (tap_num),
    .o_tap_den   (tap_den)
  );

  // One wait cycle per access keeps readdata registered; answer on second edge
  assign req = (i_avs_read | i_avs_write) & ~answered_reg;

  always @* begin
    ctrl_next = voltage_reference_control_reg;
    if (req && i_avs_write && i_avs_address == `CVR_ADDR_CTRL && i_avs_byteenable[0]) begin
      ctrl_next = i_avs_writedata[7:0];   // see (R1) see (R2) see (R12)
    end
  end

  always @* begin
    rdata_next = `CVR_RDATA_IDLE;
    case (i_avs_address)
      `CVR_ADDR_CTRL:   rdata_next = {24'h0, voltage_reference_control_reg};
      `CVR_ADDR_STATUS: rdata_next = {29'h0, osc_sync, o_fixed_ref_enable, o_ladder_power_en};
      `CVR_ADDR_TAP:    rdata_next = {16'h0, tap_den, tap_num};   // see (R3)
      default:          rdata_next = `CVR_RDATA_IDLE;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      voltage_reference_control_reg <= `CVR_CTRL_RESET;
      answered_reg                  <= 1'b0;
      o_avs_readdata                <= `CVR_RDATA_IDLE;
      o_avs_waitrequest             <= 1'b1;
    end else begin
      voltage_reference_control_reg <= ctrl_next;
      answered_reg                  <= req;
      o_avs_waitrequest             <= ~req;
      if (req && i_avs_read) begin
        o_avs_readdata <= rdata_next;
      end
    end
  end

  // Outputs track the register, fixed enable and clamp also the synchronised oscillator, with no dependence on any comparator mode
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_ladder_power_en     <= 1'b0;
      o_ladder_range_select <= 1'b0;
      o_ladder_level_code   <= 4'h0;
      o_cmp1_ladder_select  <= 1'b0;
      o_cmp2_ladder_select  <= 1'b0;
      o_fixed_ref_enable    <= 1'b0;
      o_fixed_ref_clamp     <= 1'b1;
    end else begin
      o_ladder_power_en     <= ctrl_next[`CVR_BIT_CMP1_SEL] |
                               ctrl_next[`CVR_BIT_CMP2_SEL];            // see (R6) see (R10)
      o_ladder_range_select <= ctrl_next[`CVR_BIT_RANGE];               // see (R1) see (R12)
      o_ladder_level_code   <= ctrl_next[`CVR_LEVEL_HI:`CVR_LEVEL_LO];  // see (R2)
      o_cmp1_ladder_select  <= ctrl_next[`CVR_BIT_CMP1_SEL];            // see (R4)
      o_cmp2_ladder_select  <= ctrl_next[`CVR_BIT_CMP2_SEL];            // see (R5)
      o_fixed_ref_enable    <= ctrl_next[`CVR_BIT_FIXED_EN] | osc_sync; // see (R7) see (R8)
      o_fixed_ref_clamp     <= ~(ctrl_next[`CVR_BIT_FIXED_EN] | osc_sync); // see (R9)
    end
  end
endmodule // cvr_ref_ctrl

// ===== rtl/cvr_sync2.v
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module cvr_sync2 (
  input  wire i_core_clk,   // Core clock
  input  wire i_reset_n,    // Sync reset, active low
  input  wire i_async,      // Asynchronous level
  output reg  o_sync        // Synchronised level
);
  reg meta_reg;
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      meta_reg <= 1'b0;
      o_sync   <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule // cvr_sync2

// ===== tb/cvr_analog_model.sv
// Behavioural model of the reference ladder and the two comparator inputs
`timescale 1ns/100ps
module cvr_analog_model (
  input  wire       i_power_en, i_low, i_sel1, i_sel2, i_fixed_en, i_clamp, // Controls
  input  wire [3:0] i_level,  // Level code
  output wire [7:0] o_ref1,   // Comparator 1 input in 1/96 supply, ff is fixed
  output wire [7:0] o_ref2    // Comparator 2 input
);
  // Unpowered ladder reads 0 so a missing power enable cannot pass
  wire [7:0] lad = !i_power_en ? 8'h00 : i_low ? {2'h0, i_level, 2'h0}
                 : 8'h18 + {4'h0, i_level} * 8'h03;
  wire [7:0] fix = (i_fixed_en && !i_clamp) ? 8'hff : 8'h00;
  assign o_ref1 = i_sel1 ? lad : fix;
  assign o_ref2 = i_sel2 ? lad : fix;
endmodule // cvr_analog_model

// ===== tb/cvr_ref_ctrl_assertions.sv
// Checker for the comparator voltage reference control block
`timescale 1ns/100ps
module cvr_ref_ctrl_assertions (
  input logic i_core_clk, i_reset_n, i_avs_write, o_avs_waitrequest, // Clock and bus
  input logic i_high_freq_internal_osc, o_fixed_ref_enable, o_fixed_ref_clamp, // Fixed ref
  input logic o_ladder_power_en, o_ladder_range_select, o_cmp1_ladder_select, // Ladder
  input logic o_cmp2_ladder_select, input logic [1:0] i_avs_address, // Select, address
  input logic [31:0] i_avs_writedata, input logic [3:0] i_avs_byteenable, o_ladder_level_code
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  wire wr = i_avs_write && i_avs_address == 2'h0 && i_avs_byteenable[0] && !o_avs_waitrequest;
  level_code_a: assert property (wr |-> o_ladder_level_code == i_avs_writedata[3:0])
    else $error("level code");
  range_sel_a: assert property (wr |-> o_ladder_range_select == i_avs_writedata[5])
    else $error("range");
  cmp_sel_a: assert property (wr |-> {o_cmp1_ladder_select, o_cmp2_ladder_select}
    == i_avs_writedata[7:6]) else $error("selects");
  ladder_power_a: assert property (o_ladder_power_en == (o_cmp1_ladder_select
    || o_cmp2_ladder_select)) else $error("power");
  fixed_en_a: assert property (wr && i_avs_writedata[4] |-> o_fixed_ref_enable)
    else $error("fixed enable");
  osc_forces_a: assert property (i_high_freq_internal_osc [*3] |=> o_fixed_ref_enable)
    else $error("osc");
  clamp_inv_a: assert property (o_fixed_ref_clamp != o_fixed_ref_enable)
    else $error("clamp");
  level_hold_a: assert property ($changed(o_ladder_level_code) && $past(i_reset_n)
    |-> $past(i_avs_write)) else $error("hold");
  cover property (wr && i_avs_writedata[4]);
  cover property (o_ladder_power_en && o_ladder_range_select);
  cover property (i_high_freq_internal_osc && o_fixed_ref_enable);
endmodule // cvr_ref_ctrl_assertions
bind cvr_ref_ctrl cvr_ref_ctrl_assertions i_cvr_ref_ctrl_assertions (.*);

// ===== tb/cvr_ref_ctrl_bench.sv
// Self-checking bench for the comparator voltage reference control block
`timescale 1ns/100ps
module cvr_ref_ctrl_bench;
  logic clk = 0, rst_n = 0, rd = 0, we = 0, osc = 0, wt, pw, lo, s1, s2, fe, cl;
  logic [1:0] ad = 0;
  logic [3:0] be = 0, lvl;
  logic [7:0] r1, r2;
  logic [31:0] wd = 0, q, rdat;
  int num_errors = 0, check_count = 0;
  always #5 clk = ~clk;
  cvr_ref_ctrl i_cvr_ref_ctrl (.i_core_clk(clk), .i_reset_n(rst_n), .i_avs_address(ad),
    .i_avs_read(rd), .i_avs_write(we), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_high_freq_internal_osc(osc),
    .o_ladder_power_en(pw), .o_ladder_range_select(lo), .o_ladder_level_code(lvl),
    .o_cmp1_ladder_select(s1), .o_cmp2_ladder_select(s2), .o_fixed_ref_enable(fe),
    .o_fixed_ref_clamp(cl));
  cvr_analog_model i_cvr_analog_model (.i_power_en(pw), .i_low(lo), .i_sel1(s1), .i_sel2(s2),
    .i_fixed_en(fe), .i_clamp(cl), .i_level(lvl), .o_ref1(r1), .o_ref2(r2));
  task conclude;
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request held until waitrequest is sampled low; read data taken at that edge
  task bus(input logic w, input logic [1:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    rd <= !w; we <= w; ad <= a; wd <= d; be <= b;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    rd <= 0; we <= 0;
  endtask
  task t_reset;
    bus(0, 0, 0, 4'h1);
    chk("ctrl", 0, q);
    chk("clamp", 1, cl);
  endtask
  task t_ladder;
    for (int r = 0; r < 2; r++) for (int l = 0; l < 16; l++) begin
      bus(1, 0, {24'h0, 2'b10, r[0], 1'b0, l[3:0]}, 4'h1);
      chk("ref1", r ? 4 * l : 24 + 3 * l, r1);
      chk("ref2", 0, r2);
    end
  endtask
  task t_fixed;
    bus(1, 0, 32'h50, 4'h1);
    repeat (4) @(posedge clk);
    chk("ref1", 8'hff, r1);
    chk("ref2", 24, r2);
    bus(0, 1, 0, 4'h1);
    chk("status", 32'h3, q);
    bus(0, 2, 0, 4'h1);
    chk("tap", {16'h0, 8'd32, 8'd8}, q);
    bus(1, 0, 0, 4'h0);
    chk("power", 1, pw);
    bus(0, 3, 0, 4'h1);
    chk("unmapped", 0, q);
    bus(1, 0, 0, 4'h1);
    chk("clamp", 1, cl);
    chk("power", 0, pw);
  endtask
  task t_osc;
    osc <= 1;
    repeat (4) @(posedge clk);
    chk("fixed", 1, fe);
    bus(0, 0, 0, 4'h1);
    chk("ctrl", 0, q);
    osc <= 0;
    repeat (4) @(posedge clk);
    chk("fixed", 0, fe);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    t_reset;
    t_ladder;
    t_fixed;
    t_osc;
    conclude;
  end
  initial begin
    #20000;
    num_errors++;
    conclude;
  end
endmodule // cvr_ref_ctrl_bench
